// File: logic/irt_pkg.sv
// Constants, field layouts and types for the infrared carrier timer.
// Assumes a 100 MHz core clock and a classic Wishbone register slave.
//
// Behaviour
// - Tick clock is core clock over two-power divider
// - Carrier high byte+1, low byte+1 ticks
// - Timer runs only while unit enabled
// - Counter wrap sets overflow flag, may interrupt
// - Carrier timing, polarity, data latched per interval
// - Pin idles at polarity level when enabled
// - Transmit countdown clocked by carrier or tick
// - Data one sends carrier, zero sends idle
// - Transmit starts on enable and transmit select
// - At zero reload, resample, update, flag, interrupt
// - Interval lasts interval register plus one clocks
// - Envelope pin carries data bit, polarity inverted
// - Envelope 01 modulated, 10 plain carrier out
// - Receive counts up from first qualified edge
// - Receive counter clocked by carrier or tick
// - Later edges capture level and counter value
// - Receive continues until transmit or disable
// - Burst mode counts edges, no capture
// - Burst mode flags two carrier periods silent
// - Entering burst mode loads interval with one
// - Burst mode keeps reload and clock select
// - Disabled pin follows manual level and drive
package irt_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_CONTROL  = 8'h00;
    localparam logic [7:0] ADR_CARRIER  = 8'h04;
    localparam logic [7:0] ADR_INTERVAL = 8'h08;
    localparam logic [7:0] ADR_COUNTER  = 8'h0C;
    localparam logic [7:0] ADR_STATUS   = 8'h10;
    localparam logic [7:0] ADR_POWER    = 8'h14;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int ST_INTERVAL_FLAG = 0;    // Status: interval flag
    localparam int ST_OVERFLOW_FLAG = 1;    // Status: overflow flag
    localparam int ST_DATA_BIT      = 2;    // Status: modulation data bit
    localparam int PW_MANUAL_LEVEL  = 0;    // Power: manual pin level
    localparam int PW_MANUAL_DRIVE  = 1;    // Power: manual pin drive
    localparam logic [15:0] RST_WORD     = 16'h0000;
    localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
    localparam logic [15:0] BURST_LOAD   = 16'h0001;
    localparam logic [1:0]  GAP_PERIODS  = 2'h2;   // Silent carrier periods
    localparam logic [1:0]  ENV_MOD      = 2'h1;   // Envelope, modulated
    localparam logic [1:0]  ENV_PLAIN    = 2'h2;   // Envelope, plain carrier
    localparam logic [1:0]  EDGE_FALL    = 2'h0;
    localparam logic [1:0]  EDGE_RISE    = 2'h1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    // Control register, bit 0 is the unit enable
    typedef struct packed {
        logic [1:0] reserved;
        logic       burst_count_enable;
        logic       capture_reload_bit;
        logic [1:0] edge_select;
        logic [1:0] envelope_select;
        logic [2:0] tick_divider;
        logic       fine_clock_select;
        logic       output_polarity;
        logic       interval_interrupt_enable;
        logic       transmit_select;
        logic       unit_enable_bit;
    } irt_ctrl_t;

    // Carrier timing register
    typedef struct packed {
        logic [7:0] carrier_high_byte;
        logic [7:0] carrier_low_byte;
    } irt_carrier_t;

    // Operating state, one-hot
    typedef enum logic [3:0] {
        ST_IDLE    = 4'h1,
        ST_TX      = 4'h2,
        ST_RX_WAIT = 4'h4,
        ST_RX_RUN  = 4'h8
    } irt_state_t;

endpackage

// File: logic/irt_carrier_gen.sv
// Carrier waveform generator: high and low phases counted in ticks.
// Assumes a one-cycle tick strobe and synchronous restart from its user.
`timescale 1ns/1ps
module irt_carrier_gen #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_b,
    // Control
    input  wire logic         i_restart,
    input  wire logic         i_tick,
    input  wire logic [W-1:0] i_high,
    input  wire logic [W-1:0] i_low,
    // Waveform
    output logic              o_level,
    output logic              o_period_end
);

    // ------------------------------------------------------------
    // Phase counter
    // ------------------------------------------------------------
    logic         phase_q;      // 1 while in the high phase
    logic [W-1:0] cnt_q;        // Ticks spent in the current phase
    wire  [W-1:0] limit = phase_q ? i_high : i_low;
    wire          last  = i_tick && (cnt_q == limit);

    // Each phase lasts its byte plus one ticks
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            phase_q <= 1'b1;
            cnt_q   <= '0;
        end else if (i_restart) begin
            // Restart always begins a fresh high phase
            phase_q <= 1'b1;
            cnt_q   <= '0;
        end else if (last) begin
            phase_q <= ~phase_q;
            cnt_q   <= '0;
        end else if (i_tick) begin
            cnt_q   <= cnt_q + 1'b1;
        end
    end

    assign o_level      = phase_q;
    // A period ends when its low phase runs out
    assign o_period_end = last && !phase_q && !i_restart;

endmodule

// File: logic/irt_timer.sv
// Infrared carrier timer: carrier generator, modulator and edge capture.
// Assumes the receive pin is already synchronous to the core clock.
//
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module irt_timer (
    // Clock and reset
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_RST_B,
    // Wishbone slave
    input  wire logic        I_WB_CYC,
    input  wire logic        I_WB_STB,
    input  wire logic        I_WB_WE,
    input  wire logic [7:0]  I_WB_ADR,
    input  wire logic [3:0]  I_WB_SEL,
    input  wire logic [31:0] I_WB_DAT,
    output logic      [31:0] O_WB_DAT,
    output logic             O_WB_ACK,
    // Infrared pins
    input  wire logic        I_RECEIVE_PIN,
    output logic             O_EMIT_PIN,
    output logic             O_EMIT_PIN_OE,
    output logic             O_ENVELOPE_PIN,
    // Interrupt request
    output logic             O_IRQ
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    irt_pkg::irt_ctrl_t    ctl_q;       // Control register
    irt_pkg::irt_carrier_t ca_q;        // Carrier timing, software copy
    irt_pkg::irt_carrier_t ca_lat_q;    // Carrier timing, interval copy
    irt_pkg::irt_state_t   st_q;        // Operating state
    irt_pkg::irt_state_t   st_d;
    logic [15:0] mt_q;                  // Modulation interval
    logic [15:0] mt_d;
    logic [15:0] irv_q;                 // Interval counter value
    logic [15:0] irv_d;
    logic        data_q;                // Modulation data bit
    logic        data_d;
    logic        dat_lat_q;             // Data bit for this interval
    logic        pol_lat_q;             // Polarity for this interval
    logic        if_q;                  // Interval flag
    logic        ov_q;                  // Overflow flag
    logic [1:0]  pwr_q;                 // Manual level and drive
    logic [6:0]  presc_q;               // Tick prescaler
    logic        rx_prev_q;             // Receive pin, last cycle
    logic        burst_prev_q;          // Burst bit, last cycle
    logic [1:0]  gap_q;                 // Carrier periods since an edge

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // A request is taken in its first cycle, the write lands on the
    // edge where ack is seen high, so ack is always one cycle late.
    wire req      = I_WB_CYC && I_WB_STB;
    wire wr_stb   = req && I_WB_WE && O_WB_ACK;
    wire sel_ctl  = I_WB_ADR == irt_pkg::ADR_CONTROL;
    wire sel_ca   = I_WB_ADR == irt_pkg::ADR_CARRIER;
    wire sel_mt   = I_WB_ADR == irt_pkg::ADR_INTERVAL;
    wire sel_irv  = I_WB_ADR == irt_pkg::ADR_COUNTER;
    wire sel_st   = I_WB_ADR == irt_pkg::ADR_STATUS;
    wire sel_pwr  = I_WB_ADR == irt_pkg::ADR_POWER;
    wire wr_ctl   = wr_stb && sel_ctl;
    wire wr_ca    = wr_stb && sel_ca;
    wire wr_mt    = wr_stb && sel_mt;
    wire wr_irv   = wr_stb && sel_irv;
    wire wr_st    = wr_stb && sel_st && I_WB_SEL[0];
    wire wr_pwr   = wr_stb && sel_pwr && I_WB_SEL[0];

    // Byte-lane merge for the 16-bit registers
    function automatic logic [15:0] merge(input logic [15:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        merge = {sel[1] ? new_v[15:8] : old_v[15:8],
                 sel[0] ? new_v[7:0]  : old_v[7:0]};
    endfunction

    wire [15:0] status_word = {13'h0000, data_q, ov_q, if_q};
    // Unmapped addresses answer with zero
    wire [15:0] rd_word =
        sel_ctl ? 16'(ctl_q)  :
        sel_ca  ? 16'(ca_q)   :
        sel_mt  ? mt_q        :
        sel_irv ? irv_q       :
        sel_st  ? status_word :
        sel_pwr ? {14'h0000, pwr_q} : 16'h0000;

    // ------------------------------------------------------------
    // Tick clock
    // ------------------------------------------------------------
    wire        en     = ctl_q.unit_enable_bit;
    wire [6:0]  mask   = 7'((8'h01 << ctl_q.tick_divider) - 8'h01);
    // Tick once every two-power-divider core cycles
    wire        tick   = en && (&(presc_q | ~mask));

    // ------------------------------------------------------------
    // Carrier generator
    // ------------------------------------------------------------
    wire run_tx   = st_q == irt_pkg::ST_TX;
    wire run_rx   = st_q == irt_pkg::ST_RX_RUN;
    // Transmit begins on enable with transmit selected, either order
    wire tx_start = en && ctl_q.transmit_select && !run_tx;
    wire carr_lvl;
    wire per_end;
    // Counter clock: carrier period or tick
    wire cnt_clk  = ctl_q.fine_clock_select ? tick : per_end;
    wire tx_zero  = run_tx && cnt_clk && (irv_q == irt_pkg::RST_WORD);
    // Live timing in receive, latched timing in transmit
    wire irt_pkg::irt_carrier_t ca_use = run_tx ? ca_lat_q : ca_q;

    irt_carrier_gen #(
        .W (8)
    ) u_carrier (
        .i_clk        (I_CORE_CLK),
        .i_rst_b      (I_RST_B),
        .i_restart    (!en || tx_start || tx_zero),
        .i_tick       (tick),
        .i_high       (ca_use.carrier_high_byte),
        .i_low        (ca_use.carrier_low_byte),
        .o_level      (carr_lvl),
        .o_period_end (per_end)
    );

    // ------------------------------------------------------------
    // Receive edge detection
    // ------------------------------------------------------------
    wire rise   = I_RECEIVE_PIN && !rx_prev_q;
    wire fall   = !I_RECEIVE_PIN && rx_prev_q;
    // 00 falling, 01 rising, 1x both edges
    wire qual   = (ctl_q.edge_select == irt_pkg::EDGE_FALL) ? fall :
                  (ctl_q.edge_select == irt_pkg::EDGE_RISE) ? rise :
                  (rise || fall);
    wire rx_cap = run_rx && qual;
    wire burst  = ctl_q.burst_count_enable;
    wire b_rise = burst && !burst_prev_q;
    wire rx_clr = rx_cap && ctl_q.capture_reload_bit;
    wire ov_set = run_rx && cnt_clk && !rx_clr &&
                  (irv_q == irt_pkg::COUNT_MAX);
    // Two silent carrier periods mark the start of a space
    wire loss   = run_rx && burst && per_end && !qual &&
                  (gap_q == irt_pkg::GAP_PERIODS - 2'h1);
    wire if_set = tx_zero || (rx_cap && !burst) || loss;

    // ------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------
    // Runs only while enabled receive lasts until transmit
    // is selected or the unit disabled
    always_comb begin
        case (st_q)
            irt_pkg::ST_IDLE,
            irt_pkg::ST_TX,
            irt_pkg::ST_RX_WAIT,
            irt_pkg::ST_RX_RUN: begin
                if (!en) begin
                    st_d = irt_pkg::ST_IDLE;
                end else if (ctl_q.transmit_select) begin
                    st_d = irt_pkg::ST_TX;
                end else if (run_rx || qual) begin
                    // First qualified edge starts the count
                    st_d = irt_pkg::ST_RX_RUN;
                end else begin
                    st_d = irt_pkg::ST_RX_WAIT;
                end
            end
            default: begin
                st_d = irt_pkg::ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Counter, interval and data next values
    // ------------------------------------------------------------
    // Hardware updates win over a software write in the same cycle
    always_comb begin
        irv_d = wr_irv ? merge(irv_q, I_WB_DAT, I_WB_SEL) : irv_q;
        if (tx_start) begin
            irv_d = mt_q;
        end else if (tx_zero) begin
            irv_d = mt_q;
        end else if (run_tx && cnt_clk) begin
            irv_d = irv_q - 16'h0001;
        end else if (st_q == irt_pkg::ST_RX_WAIT && qual) begin
            irv_d = irt_pkg::RST_WORD;
        end else if (rx_clr) begin
            irv_d = irt_pkg::RST_WORD;
        end else if (run_rx && cnt_clk) begin
            irv_d = irv_q + 16'h0001;                  // Wraps
        end
    end

    always_comb begin
        mt_d = wr_mt ? merge(mt_q, I_WB_DAT, I_WB_SEL) : mt_q;
        if (b_rise) begin
            mt_d = irt_pkg::BURST_LOAD;
        end else if (rx_cap && burst) begin
            mt_d = mt_q + 16'h0001;
        end else if (rx_cap) begin
            mt_d = irv_q;
        end
    end

    always_comb begin
        data_d = wr_st ? I_WB_DAT[irt_pkg::ST_DATA_BIT] : data_q;
        if (rx_cap && !burst) begin
            data_d = I_RECEIVE_PIN;
        end
    end

    // ------------------------------------------------------------
    // Pin output next values
    // ------------------------------------------------------------
    wire carr_out = carr_lvl ^ pol_lat_q;
    // Data one: carrier, data zero: idle level
    wire mod_out  = dat_lat_q ? carr_out : pol_lat_q;
    wire env_on   = (ctl_q.envelope_select == irt_pkg::ENV_MOD) ||
                    (ctl_q.envelope_select == irt_pkg::ENV_PLAIN);
    // Plain carrier only in the second envelope mode
    wire tx_out   = (ctl_q.envelope_select == irt_pkg::ENV_PLAIN) ?
                    carr_out : mod_out;
    // Disabled: manual level otherwise idle at polarity
    wire emit_d   = !en    ? pwr_q[irt_pkg::PW_MANUAL_LEVEL] :
                    run_tx ? tx_out : ctl_q.output_polarity;
    wire emit_oe_d = en || pwr_q[irt_pkg::PW_MANUAL_DRIVE];
    // Envelope follows the interval data bit, inverted when the interval polarity is one
    wire env_d    = run_tx && env_on && (dat_lat_q ^ pol_lat_q);
    // Interrupt follows either flag, both gated by the interval interrupt enable
    wire irq_d    = ctl_q.interval_interrupt_enable && (if_q || ov_q);

    // ------------------------------------------------------------
    // Bus and control registers
    // ------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_WB_ACK <= 1'b0;
            O_WB_DAT <= 32'h00000000;
            ctl_q    <= irt_pkg::irt_ctrl_t'(irt_pkg::RST_WORD);
            ca_q     <= irt_pkg::irt_carrier_t'(irt_pkg::RST_WORD);
            pwr_q    <= 2'h0;
        end else begin
            // One-cycle ack, dropped the cycle after it is given
            O_WB_ACK <= req && !O_WB_ACK;
            O_WB_DAT <= {16'h0000, rd_word};
            if (wr_ctl) begin
                ctl_q <= irt_pkg::irt_ctrl_t'(merge(16'(ctl_q), I_WB_DAT,
                                                    I_WB_SEL));
            end
            if (wr_ca) begin
                ca_q <= irt_pkg::irt_carrier_t'(merge(16'(ca_q), I_WB_DAT,
                                                      I_WB_SEL));
            end
            if (wr_pwr) begin
                pwr_q <= I_WB_DAT[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Timer state
    // ------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            st_q         <= irt_pkg::ST_IDLE;
            irv_q        <= irt_pkg::RST_WORD;
            mt_q         <= irt_pkg::RST_WORD;
            data_q       <= 1'b0;
            rx_prev_q    <= 1'b1;   // Idle high: no false edge
            burst_prev_q <= 1'b0;
            presc_q      <= 7'h00;
        end else begin
            st_q         <= st_d;
            irv_q        <= irv_d;
            mt_q         <= mt_d;
            data_q       <= data_d;
            rx_prev_q    <= I_RECEIVE_PIN;
            burst_prev_q <= burst;
            presc_q      <= en ? presc_q + 7'h01 : 7'h00;
        end
    end

    // Interval copy of timing, data and polarity
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            ca_lat_q  <= irt_pkg::irt_carrier_t'(irt_pkg::RST_WORD);
            dat_lat_q <= 1'b0;
            pol_lat_q <= 1'b0;
        end else if (tx_start || tx_zero) begin
            ca_lat_q  <= ca_q;
            dat_lat_q <= data_q;
            pol_lat_q <= ctl_q.output_polarity;
        end
    end

    // Sticky flags, a set in the clearing cycle wins
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            if_q  <= 1'b0;
            ov_q  <= 1'b0;
            gap_q <= 2'h0;
        end else begin
            if_q  <= if_set ||
                     (if_q && !(wr_st &&
                      I_WB_DAT[irt_pkg::ST_INTERVAL_FLAG]));
            ov_q  <= ov_set ||
                     (ov_q && !(wr_st &&
                      I_WB_DAT[irt_pkg::ST_OVERFLOW_FLAG]));
            if (!run_rx || qual) begin
                gap_q <= 2'h0;
            end else if (per_end && gap_q != irt_pkg::GAP_PERIODS) begin
                gap_q <= gap_q + 2'h1;
            end
        end
    end

    // Pin and interrupt outputs, all from flip-flops
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_EMIT_PIN     <= 1'b0;
            O_EMIT_PIN_OE  <= 1'b0;
            O_ENVELOPE_PIN <= 1'b0;
            O_IRQ          <= 1'b0;
        end else begin
            O_EMIT_PIN     <= emit_d;
            O_EMIT_PIN_OE  <= emit_oe_d;
            O_ENVELOPE_PIN <= env_d;
            O_IRQ          <= irq_d;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_B);

    sequence tx_begin_s;
        tx_start;
    endsequence
    sequence tx_loaded_s;
        run_tx && irv_q == $past(mt_q);
    endsequence

    tick_divide_a: assert property (en && ctl_q.tick_divider == 3'h0 |->
        tick) else $error("tick missing at divider zero");
    tx_begin_a: assert property (tx_begin_s |=> tx_loaded_s)
        else $error("transmit start did not load counter");
    tx_reload_a: assert property (tx_zero |=> irv_q == $past(mt_q) &&
        if_q) else $error("zero did not reload and flag");
    tx_count_a: assert property (run_tx && cnt_clk && !tx_zero &&
        !tx_start |=> irv_q == $past(irv_q) - 16'h0001)
        else $error("countdown step wrong");
    ovf_flag_a: assert property (ov_set |=> ov_q [*2] or
        (ov_q ##1 !ov_q)) else $error("overflow flag not set");
    idle_level_a: assert property (run_tx && en && !dat_lat_q &&
        ctl_q.envelope_select != irt_pkg::ENV_PLAIN |=>
        O_EMIT_PIN == $past(pol_lat_q))
        else $error("idle level wrong");
    manual_pin_a: assert property (!en |=> O_EMIT_PIN ==
        $past(pwr_q[0]) && O_EMIT_PIN_OE == $past(pwr_q[1]))
        else $error("manual pin control ignored");
    rx_capture_a: assert property (rx_cap && !burst && !b_rise |=>
        mt_q == $past(irv_q) && data_q == $past(I_RECEIVE_PIN))
        else $error("capture wrong");
    burst_load_a: assert property (b_rise |=> mt_q ==
        irt_pkg::BURST_LOAD) else $error("burst entry load");
    envelope_a: assert property (run_tx && env_on |=> O_ENVELOPE_PIN ==
        $past(dat_lat_q ^ pol_lat_q))
        else $error("envelope pin wrong");
    irq_follow_a: assert property (if_q && ctl_q.interval_interrupt_enable
        |=> O_IRQ) else $error("interrupt not raised");

endmodule

// File: tb/irt_ir_partner.sv
// Far-side model: receiver module on the receive pin, emitter diode count.
// Assumes the bench sets the half period and raises the burst request.
`timescale 1ns/1ps
module irt_ir_partner (
    input  wire logic        i_clk,
    input  wire logic        i_go,     // Send a burst
    input  wire logic [7:0]  i_half,   // Half period, core cycles
    input  wire logic        i_emit,   // Emitter diode drive
    output logic             o_rx,     // Receiver output
    output logic [15:0]      o_pulses  // Light pulses seen
);
    logic [7:0] cnt_q;   // Phase counter
    logic       emit_q;  // Last emitter level
    initial begin
        cnt_q = 8'h00;
        emit_q = 1'b0;
        o_rx = 1'b1;
        o_pulses = 16'h0000;
    end
    // Receiver idles high like a pulled-up open output
    always @(posedge i_clk) begin
        emit_q <= i_emit;
        if (i_emit && !emit_q)
            o_pulses <= o_pulses + 16'h0001;
        if (!i_go) begin
            cnt_q <= 8'h00;
            o_rx <= 1'b1;
        end else if (cnt_q == i_half - 8'h01) begin
            cnt_q <= 8'h00;
            o_rx <= ~o_rx;
        end else
            cnt_q <= cnt_q + 8'h01;
    end
endmodule

// File: tb/test_irt_timer.sv
// Bench for the infrared timer: bus tasks and directed scenarios.
// Assumes the slave acks one cycle after each request.
`timescale 1ns/1ps
module test_irt_timer;
    logic        clk = 1'b0;    // Core clock
    logic        rst_b = 1'b0;  // Reset, active low
    logic        cyc = 1'b0;    // Bus cycle
    logic        stb = 1'b0;    // Bus strobe
    logic        we = 1'b0;     // Write select
    logic [3:0]  sel = 4'h0;    // Byte lanes
    logic        go = 1'b0;     // Partner burst request
    logic [7:0]  adr = 8'h00;   // Byte address
    logic [31:0] wdat = 32'h0;  // Write data
    logic [31:0] rdat, r;       // Read data, last taken
    logic        rx, emit, oe, env, irq, ack;
    logic [15:0] pulses, p0;    // Emitter pulse count
    int          fails = 0, num_checks = 0, cycles = 0;
    always #5 clk = ~clk;
    irt_timer irt_timer_inst (.I_CORE_CLK(clk), .I_RST_B(rst_b),
        .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
        .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
        .O_WB_ACK(ack), .I_RECEIVE_PIN(rx), .O_EMIT_PIN(emit),
        .O_EMIT_PIN_OE(oe), .O_ENVELOPE_PIN(env), .O_IRQ(irq));
    irt_ir_partner irt_ir_partner_inst (.i_clk(clk), .i_go(go),
        .i_half(8'h0A), .i_emit(emit), .o_rx(rx), .o_pulses(pulses));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask
    // Classic single cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [15:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h3;
        adr <= a;
        wdat <= {16'h0000, d};
        do @(posedge clk); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        sel <= 4'h0;
    endtask
    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            finish_test();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        wb(0, 8'h04, 0); chk(r, 0);
        wb(1, 8'h04, 16'h0101); wb(0, 8'h04, 0); chk(r, 32'h0101);
        wb(0, 8'h30, 0); chk(r, 0);
        wb(1, 8'h14, 16'h0003); repeat (2) @(posedge clk);
        chk({emit, oe}, 2'b11);
        $display("test registers done");
        // Transmit, data one, 12 tick interval, modulated envelope
        wb(1, 8'h08, 16'h000B); wb(1, 8'h10, 16'h0004);
        wb(1, 8'h00, 16'h0117); p0 = pulses;
        for (int i = 0; i < 40 && irq !== 1'b1; i++) @(posedge clk);
        chk(irq, 1);
        chk(env, 1);
        repeat (48) @(posedge clk);
        chk(pulses - p0 >= 16'h0008, 1);
        wb(1, 8'h00, 0);
        wb(0, 8'h10, 0); chk(r[0], 1);
        wb(1, 8'h10, 16'h0001); wb(0, 8'h10, 0);
        chk(r[1:0], 0);
        repeat (2) @(posedge clk);
        chk(irq, 0);
        wb(1, 8'h00, 16'h000B); repeat (40) @(posedge clk);
        chk(emit, 1);
        wb(1, 8'h00, 0);
        // Plain carrier on the emitter, inverted data on the envelope
        wb(1, 8'h00, 16'h020B); p0 = pulses;
        repeat (40) @(posedge clk);
        chk(pulses - p0 >= 16'h0005, 1);
        chk(env, 1);
        wb(1, 8'h00, 0);
        $display("test transmit done");
        // Receive, rising edges every 20 cycles, reload on capture
        wb(1, 8'h00, 16'h1411); go <= 1'b1;
        repeat (100) @(posedge clk);
        wb(0, 8'h08, 0); chk(r >= 17 && r <= 21, 1);
        wb(0, 8'h10, 0); chk(r[2], 1);
        go <= 1'b0; wb(1, 8'h10, 16'h0001);
        // Slow carrier, so edges every 20 cycles never look like a gap
        wb(1, 8'h04, 16'h0F0F);
        wb(1, 8'h00, 16'h3411); wb(0, 8'h08, 0); chk(r, 1);
        go <= 1'b1; repeat (70) @(posedge clk);
        wb(1, 8'h10, 16'h0001); wb(0, 8'h08, 0);
        chk(r >= 3 && r <= 6, 1);
        wb(0, 8'h10, 0); chk(r[0], 0);
        go <= 1'b0; repeat (120) @(posedge clk);
        wb(0, 8'h10, 0); chk(r[0], 1);
        $display("test receive done");
        finish_test();
    end
endmodule
